// File: src/adn_pkg.sv
// Shared constants for the anemometer diagnostic status block
package adn_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TRIG_LOSS_S   = 1;
  localparam int unsigned TRIG_LOSS_CYC = TRIG_LOSS_S * CLK_HZ;
  localparam int unsigned JITTER_PCT    = 5;
  localparam int unsigned PCT_FULL      = 100;
  localparam int          IVL_W         = 28;

  // Status word layout
  localparam int DIAG_W        = 32;
  localparam int BIT_AMP_LOW   = 0;
  localparam int BIT_AMP_HIGH  = 1;
  localparam int BIT_TRACKING  = 2;
  localparam int BIT_DELTA_C   = 3;
  localparam int BIT_ACQUIRING = 4;
  localparam int BIT_LOW_VOLT  = 5;
  localparam int BIT_TRIG_ERR  = 6;
  localparam int BIT_HUMIDITY  = 7;
  localparam int BIT_MEM_ERR   = 8;
  localparam logic [DIAG_W-1:0] DIAG_RESET = 32'h0000_0000;

  // Analog thresholds (mm/s, mV, 0.1 %RH)
  localparam int          SPD_W        = 20;
  localparam logic [SPD_W-1:0] DELTA_C_MAX_MMS = 20'h0_0938; // 2.360 m/s
  localparam int          VOLT_W       = 16;
  localparam logic [VOLT_W-1:0] LOW_VOLT_MV = 16'h2328;     // 9.0 V
  localparam int          RH_W         = 10;
  localparam logic [RH_W-1:0] RH_WARN_DPCT = 10'h320;       // 80.0 %

  // Value sent while acquiring
  localparam logic [31:0] FLOAT_NAN = 32'h7fc0_0000;

  // Bus select and addressing
  localparam logic BUS_SYNC_DEV = 1'h0;
  localparam logic BUS_PERIPH   = 1'h1;
  localparam int   ADDR_W       = 7;
  localparam logic [ADDR_W-1:0] ADDR_MIN      = 7'h01;
  localparam logic [ADDR_W-1:0] SYNC_ADDR_MAX = 7'h0e;
  localparam logic [ADDR_W-1:0] PERI_ADDR_MAX = 7'h78;

  // Operating mode codes
  localparam int   MODE_W       = 5;
  localparam logic [MODE_W-1:0] MODE_HOST_TRIG = 5'h00;

  // Requests
  typedef enum logic [1:0] {
    ADN_REQ_MEASURE  = 2'b00,
    ADN_REQ_HOUSEKP  = 2'b01,
    ADN_REQ_GRP_TRIG = 2'b10
  } adn_req_t;

  // Response buffer
  localparam int MEM_AW      = 3;
  localparam logic [MEM_AW-1:0] MEAS_LAST = 3'h4;
  localparam logic [MEM_AW-1:0] HK_LAST   = 3'h3;
endpackage

// File: src/adn_resp_mem.sv
// Response word buffer with registered read data
module adn_resp_mem (
  input  wire logic                          clk_i,
  input  wire logic                          we_i,
  input  wire logic [adn_pkg::MEM_AW-1:0]    waddr_i,
  input  wire logic [31:0]                   wdata_i,
  input  wire logic [adn_pkg::MEM_AW-1:0]    raddr_i,
  output logic      [31:0]                   rdata_o
);
  logic [31:0] mem_q [0:(1<<adn_pkg::MEM_AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem_q[raddr_i];
  end
endmodule

// File: src/adn_trig_mon.sv
// Trigger loss and interval jitter monitor
module adn_trig_mon #(
  parameter int unsigned LOSS_CYC = adn_pkg::TRIG_LOSS_CYC
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic trig_i,
  output logic      err_o
);
  localparam logic [adn_pkg::IVL_W-1:0] LOSS =
    adn_pkg::IVL_W'(LOSS_CYC);
  localparam logic [adn_pkg::IVL_W+7:0] PCT =
    (adn_pkg::IVL_W+8)'(adn_pkg::PCT_FULL);
  localparam logic [adn_pkg::IVL_W+7:0] JIT =
    (adn_pkg::IVL_W+8)'(adn_pkg::JITTER_PCT);

  logic [adn_pkg::IVL_W-1:0] cnt_q;
  logic [adn_pkg::IVL_W-1:0] prev_q;
  logic                      have_prev_q;
  logic                      jit_q;
  logic [adn_pkg::IVL_W-1:0] diff;
  logic                      jit_now;

  always_comb begin
    diff = (cnt_q > prev_q) ? cnt_q - prev_q : prev_q - cnt_q;
    jit_now = have_prev_q &&
      ({8'h00, diff} * PCT > {8'h00, prev_q} * JIT);
  end

  // Interval counter saturates at the loss limit
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= '0;
    end else if (trig_i) begin
      cnt_q <= '0;
    end else if (cnt_q < LOSS) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_q      <= '0;
      have_prev_q <= 1'b0;
      jit_q       <= 1'b0;
    end else if (trig_i) begin
      prev_q      <= cnt_q;
      have_prev_q <= (cnt_q < LOSS);
      jit_q       <= jit_now;
    end else if (cnt_q >= LOSS) begin
      have_prev_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      err_o <= 1'b0;
    end else begin
      err_o <= (cnt_q >= LOSS) || jit_q;
    end
  end
endmodule

// File: src/adn_diag_status.sv
// Diagnostic word assembly and response sequencer of the anemometer head
// Functional notes
// R1 - Status is a 32-bit word, one independent warning flag per bit.
// R2 - Bit 0 set while received amplitude is too low.
// R3 - Bit 1 set while received amplitude is too high.
// R4 - Bit 2 set while signal lock is poor.
// R5 - Bit 3 set when axis sound speeds differ by over 2.360 m/s.
// R6 - Bit 4 set while still acquiring the sonic signal.
// R7 - Bit 5 set when supply is below 9.0 V.
// R8 - Bit 6 set when no trigger arrived for one second.
// R9 - Bit 6 also set when trigger spacing varies over five percent.
// R10 - Bit 7 set when enclosure humidity exceeds eighty percent.
// R11 - Bit 8 set when a memory signature check fails.
// R12 - While acquiring after acquire command, send NaN and flag it.
// R13 - Measurement answer: three wind values, sonic temperature, status.
// R14 - Housekeeping answer: temperature, humidity, pitch, roll in order.
// R15 - Host picks bus: 0 synchronous device bus, 1 peripheral network.
// R16 - Synchronous device bus addresses run 1 to 14.
// R17 - Peripheral network bus addresses run 1 to 120.
// R18 - One group trigger starts measurement in up to 14 nodes.
// R19 - Host fetches each node's results with its own request.
// R20 - Peripheral network bus measures in sync without trigger command.
// R21 - Synchronous device bus allows host-triggered unfiltered mode only.
// R22 - Status bits 9 to 31 always read zero.
module adn_diag_status #(
  parameter int unsigned TRIG_LOSS_CYC = adn_pkg::TRIG_LOSS_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        bus_sel_i,
  input  wire logic [adn_pkg::ADDR_W-1:0]  node_addr_i,
  input  wire logic [adn_pkg::MODE_W-1:0]  mode_code_i,
  input  wire logic                        req_valid_i,
  input  wire logic [1:0]                  req_kind_i,
  input  wire logic [adn_pkg::ADDR_W-1:0]  req_addr_i,
  input  wire logic                        amp_low_i,
  input  wire logic                        amp_high_i,
  input  wire logic                        lock_poor_i,
  input  wire logic                        acquiring_i,
  input  wire logic                        mem_sig_fail_i,
  input  wire logic [adn_pkg::SPD_W-1:0]   snd_spd_a_i,
  input  wire logic [adn_pkg::SPD_W-1:0]   snd_spd_b_i,
  input  wire logic [adn_pkg::SPD_W-1:0]   snd_spd_c_i,
  input  wire logic [adn_pkg::VOLT_W-1:0]  supply_mv_i,
  input  wire logic [adn_pkg::RH_W-1:0]    encl_rh_i,
  input  wire logic [31:0]                 wind_x_i,
  input  wire logic [31:0]                 wind_y_i,
  input  wire logic [31:0]                 wind_z_i,
  input  wire logic [31:0]                 sonic_temp_i,
  input  wire logic [31:0]                 encl_temp_f_i,
  input  wire logic [31:0]                 encl_rh_f_i,
  input  wire logic [31:0]                 pitch_i,
  input  wire logic [31:0]                 roll_i,
  output logic                             busy_o,
  output logic                             meas_start_o,
  output logic                             self_trig_o,
  output logic                             resp_valid_o,
  output logic [31:0]                      resp_data_o,
  output logic                             resp_last_o,
  output logic [adn_pkg::DIAG_W-1:0]       diag_word_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_ok(
    input logic                       bus,
    input logic [adn_pkg::ADDR_W-1:0] own,
    input logic [adn_pkg::ADDR_W-1:0] req
  );
    logic [adn_pkg::ADDR_W-1:0] top;
    top = (bus == adn_pkg::BUS_PERIPH) ? adn_pkg::PERI_ADDR_MAX
                                       : adn_pkg::SYNC_ADDR_MAX;
    return (own >= adn_pkg::ADDR_MIN) && (own <= top) && (req == own);
  endfunction

  function automatic logic [adn_pkg::SPD_W-1:0] absdiff(
    input logic [adn_pkg::SPD_W-1:0] a,
    input logic [adn_pkg::SPD_W-1:0] b
  );
    return (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [31:0] science(
    input logic        nan_out,
    input logic [31:0] v
  );
    return nan_out ? adn_pkg::FLOAT_NAN : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  typedef enum logic [1:0] {
    ADN_S_IDLE = 2'b00,
    ADN_S_LOAD = 2'b01,
    ADN_S_SEND = 2'b10,
    ADN_S_TAIL = 2'b11
  } adn_state_t;

  adn_state_t                  state_q;
  adn_state_t                  state_d;
  logic [adn_pkg::MEM_AW-1:0]  widx_q;
  logic [adn_pkg::MEM_AW-1:0]  ridx_q;
  logic [adn_pkg::MEM_AW-1:0]  last_q;
  logic                        hk_q;
  logic [31:0]                 wdata;
  logic                        mem_we;
  logic [31:0]                 mem_rdata;
  logic                        hit;
  logic                        take_meas;
  logic                        take_hk;
  logic                        grp_trig;
  logic                        self_trig_d;
  logic                        trig_evt;
  logic                        trig_err;
  logic                        nan_out_q;
  logic [adn_pkg::DIAG_W-1:0]  diag_d;
  logic [adn_pkg::SPD_W-1:0]   spread;

  always_comb begin
    hit       = addr_ok(bus_sel_i, node_addr_i, req_addr_i);  // [R16] [R17]
    take_meas = req_valid_i && (state_q == ADN_S_IDLE) && hit &&
                (req_kind_i == adn_pkg::ADN_REQ_MEASURE);     // [R19]
    take_hk   = req_valid_i && (state_q == ADN_S_IDLE) && hit &&
                (req_kind_i == adn_pkg::ADN_REQ_HOUSEKP);
    // Broadcast, no address, only on the synchronous device bus
    grp_trig  = req_valid_i && (bus_sel_i == adn_pkg::BUS_SYNC_DEV) &&
                (req_kind_i == adn_pkg::ADN_REQ_GRP_TRIG);    // [R18] [R15]
  end

  // Self triggering only over the peripheral network bus
  always_comb begin
    self_trig_d = (bus_sel_i == adn_pkg::BUS_PERIPH) &&
                  (mode_code_i != adn_pkg::MODE_HOST_TRIG);   // [R21]
  end

  // Trigger events: group trigger, or each measurement poll on the
  // peripheral network bus, whose framing carries the synchronisation
  always_comb begin
    trig_evt = grp_trig ||
      (take_meas && (bus_sel_i == adn_pkg::BUS_PERIPH));      // [R20]
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meas_start_o <= 1'b0;
    end else begin
      meas_start_o <= trig_evt;                                // [R18]
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      self_trig_o <= 1'b0;
    end else begin
      self_trig_o <= self_trig_d;                              // [R21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger monitor

  adn_trig_mon #(
    .LOSS_CYC (TRIG_LOSS_CYC)
  ) u_trig_mon (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .trig_i  (trig_evt),
    .err_o   (trig_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic word

  always_comb begin
    spread = absdiff(snd_spd_a_i, snd_spd_b_i);
    if (absdiff(snd_spd_b_i, snd_spd_c_i) > spread) begin
      spread = absdiff(snd_spd_b_i, snd_spd_c_i);
    end
    if (absdiff(snd_spd_a_i, snd_spd_c_i) > spread) begin
      spread = absdiff(snd_spd_a_i, snd_spd_c_i);
    end
  end

  always_comb begin
    diag_d = adn_pkg::DIAG_RESET;                              // [R22] [R1]
    diag_d[adn_pkg::BIT_AMP_LOW]   = amp_low_i;                // [R2]
    diag_d[adn_pkg::BIT_AMP_HIGH]  = amp_high_i;               // [R3]
    diag_d[adn_pkg::BIT_TRACKING]  = lock_poor_i;              // [R4]
    diag_d[adn_pkg::BIT_DELTA_C]   =
      spread > adn_pkg::DELTA_C_MAX_MMS;                       // [R5]
    diag_d[adn_pkg::BIT_ACQUIRING] = acquiring_i;              // [R6] [R12]
    diag_d[adn_pkg::BIT_LOW_VOLT]  =
      supply_mv_i < adn_pkg::LOW_VOLT_MV;                      // [R7]
    diag_d[adn_pkg::BIT_TRIG_ERR]  = trig_err;                 // [R8] [R9]
    diag_d[adn_pkg::BIT_HUMIDITY]  =
      encl_rh_i > adn_pkg::RH_WARN_DPCT;                       // [R10]
    diag_d[adn_pkg::BIT_MEM_ERR]   = mem_sig_fail_i;           // [R11]
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      diag_word_o <= adn_pkg::DIAG_RESET;
    end else begin
      diag_word_o <= diag_d;                                   // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response sequencer

  always_comb begin
    state_d = state_q;
    case (state_q)
      ADN_S_IDLE: begin
        if (take_meas || take_hk) begin
          state_d = ADN_S_LOAD;
        end
      end
      ADN_S_LOAD: begin
        if (widx_q == last_q) begin
          state_d = ADN_S_SEND;
        end
      end
      ADN_S_SEND: begin
        if (ridx_q == last_q) begin
          state_d = ADN_S_TAIL;
        end
      end
      ADN_S_TAIL: begin
        state_d = ADN_S_IDLE;
      end
      default: begin
        state_d = ADN_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ADN_S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Snapshot of request kind and the NaN condition
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hk_q      <= 1'b0;
      last_q    <= '0;
      nan_out_q <= 1'b0;
    end else if (take_meas || take_hk) begin
      hk_q      <= take_hk;
      last_q    <= take_hk ? adn_pkg::HK_LAST : adn_pkg::MEAS_LAST;
      nan_out_q <= acquiring_i;                                // [R12]
    end
  end

  // Item order of each answer
  always_comb begin
    wdata = '0;
    if (hk_q) begin
      case (widx_q)                                            // [R14]
        3'h0:    wdata = encl_temp_f_i;
        3'h1:    wdata = encl_rh_f_i;
        3'h2:    wdata = pitch_i;
        default: wdata = roll_i;
      endcase
    end else begin
      case (widx_q)                                            // [R13]
        3'h0:    wdata = science(nan_out_q, wind_x_i);         // [R12]
        3'h1:    wdata = science(nan_out_q, wind_y_i);
        3'h2:    wdata = science(nan_out_q, wind_z_i);
        3'h3:    wdata = science(nan_out_q, sonic_temp_i);
        default: wdata = diag_word_o;
      endcase
    end
  end

  always_comb begin
    mem_we = (state_q == ADN_S_LOAD);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      widx_q <= '0;
    end else if (state_q == ADN_S_LOAD) begin
      widx_q <= widx_q + 1'b1;
    end else begin
      widx_q <= '0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ridx_q <= '0;
    end else if (state_q == ADN_S_SEND) begin
      ridx_q <= ridx_q + 1'b1;
    end else begin
      ridx_q <= '0;
    end
  end

  adn_resp_mem u_resp_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (widx_q),
    .wdata_i (wdata),
    .raddr_i (ridx_q),
    .rdata_o (mem_rdata)
  );

  // Read data lag by one cycle; tag them with a delayed strobe
  logic                       rd_vld_q;
  logic                       rd_last_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_vld_q  <= 1'b0;
      rd_last_q <= 1'b0;
    end else begin
      rd_vld_q  <= (state_q == ADN_S_SEND);
      rd_last_q <= (state_q == ADN_S_SEND) && (ridx_q == last_q);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      resp_valid_o <= 1'b0;
      resp_last_o  <= 1'b0;
      resp_data_o  <= '0;
    end else begin
      resp_valid_o <= rd_vld_q;
      resp_last_o  <= rd_last_q;
      resp_data_o  <= rd_vld_q ? mem_rdata : '0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_d != ADN_S_IDLE) || rd_vld_q;
    end
  end

endmodule

// File: verif/adn_diag_status_chk.sv
// Assertion checker for the anemometer diagnostic status block
module adn_diag_status_chk #(
  parameter int unsigned TRIG_LOSS_CYC = adn_pkg::TRIG_LOSS_CYC
) (
  input wire logic                       clk_i,
  input wire logic                       reset_i,
  input wire logic                       bus_sel_i,
  input wire logic [adn_pkg::ADDR_W-1:0] node_addr_i,
  input wire logic [adn_pkg::MODE_W-1:0] mode_code_i,
  input wire logic                       req_valid_i,
  input wire logic [1:0]                 req_kind_i,
  input wire logic [adn_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic                       acquiring_i,
  input wire logic [adn_pkg::VOLT_W-1:0] supply_mv_i,
  input wire logic [adn_pkg::RH_W-1:0]   encl_rh_i,
  input wire logic                       busy_o,
  input wire logic                       meas_start_o,
  input wire logic                       self_trig_o,
  input wire logic                       resp_valid_o,
  input wire logic [31:0]                resp_data_o,
  input wire logic                       resp_last_o,
  input wire logic [adn_pkg::DIAG_W-1:0] diag_word_o
);
  localparam int unsigned LIM = TRIG_LOSS_CYC + 4;
  logic [1:0]  gap_q;
  logic [31:0] idle_q;
  logic        addr_ok;
  logic        peek;
  logic        take;
  ////////////////////////////////////////////////////////////////////////
  // Request qualification and idle counting
  assign addr_ok = req_addr_i == node_addr_i && node_addr_i != 7'h00 &&
    node_addr_i <= (bus_sel_i ? adn_pkg::PERI_ADDR_MAX
                              : adn_pkg::SYNC_ADDR_MAX);
  assign peek = req_valid_i && !req_kind_i[1] && !busy_o && gap_q == 2'h2;
  assign take = peek && addr_ok;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) gap_q <= 2'h0;
    else if (req_valid_i) gap_q <= 2'h0;
    else if (gap_q != 2'h2) gap_q <= gap_q + 2'h1;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) idle_q <= 32'h0;
    else if (meas_start_o) idle_q <= 32'h0;
    else if (idle_q != LIM) idle_q <= idle_q + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  diag_upper_zero_a: assert property (
    diag_word_o[31:9] == 23'h0) else $error("high status bits set");
  low_volt_a: assert property (
    !$past(reset_i) |->
    diag_word_o[5] == $past(supply_mv_i < adn_pkg::LOW_VOLT_MV))
    else $error("low supply flag wrong");
  humidity_a: assert property (
    !$past(reset_i) |->
    diag_word_o[7] == $past(encl_rh_i > adn_pkg::RH_WARN_DPCT))
    else $error("humidity flag wrong");
  trig_loss_a: assert property (
    idle_q == LIM |-> diag_word_o[6]) else $error("trigger loss missed");
  grp_trig_a: assert property (
    req_valid_i && req_kind_i == 2'h2 && !bus_sel_i |=> meas_start_o)
    else $error("group trigger not started");
  peri_trig_a: assert property (
    req_valid_i && req_kind_i == 2'h2 && bus_sel_i |=> !meas_start_o)
    else $error("group trigger taken on network bus");
  peri_meas_a: assert property (
    take && req_kind_i == 2'h0 && bus_sel_i |=> meas_start_o)
    else $error("network measure not started");
  self_trig_a: assert property (
    !$past(reset_i) |->
    self_trig_o == $past(bus_sel_i && mode_code_i != 5'h00))
    else $error("self trigger mode wrong");
  meas_resp_a: assert property (
    take && req_kind_i == 2'h0 |-> ##8 (resp_valid_o && !resp_last_o) [*4]
    ##1 (resp_valid_o && resp_last_o)) else $error("measure answer bad");
  nan_resp_a: assert property (
    take && req_kind_i == 2'h0 && acquiring_i |->
    ##8 (resp_data_o == adn_pkg::FLOAT_NAN) [*4]) else $error("no nan");
  hk_resp_a: assert property (
    take && req_kind_i == 2'h1 |-> ##7 (resp_valid_o && !resp_last_o) [*3]
    ##1 (resp_valid_o && resp_last_o)) else $error("housekeeping bad");
  addr_refuse_a: assert property (
    peek && !addr_ok |=> !busy_o) else $error("foreign address taken");
  cover property (take && req_kind_i == 2'h0);
  cover property (take && req_kind_i == 2'h1);
  cover property (peek && !addr_ok);
  cover property ($rose(diag_word_o[6]));
endmodule

bind adn_diag_status adn_diag_status_chk #(
  .TRIG_LOSS_CYC(TRIG_LOSS_CYC)
) i_adn_diag_status_chk (.*);

// File: verif/adn_host_model.sv
// Data logger host model issuing requests to the node
module adn_host_model (
  input  wire logic                       clk_i,
  output logic                            req_valid_o,
  output logic [1:0]                      req_kind_o,
  output logic [adn_pkg::ADDR_W-1:0]      req_addr_o
);
  initial begin
    req_valid_o = 1'b0;
    req_kind_o  = 2'h3;
    req_addr_o  = 7'h00;
  end
  // One strobe per request, own fetch per node, lines flip afterwards
  task automatic send(input logic [1:0] kind,
                      input logic [6:0] addr);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_kind_o  <= kind;
    req_addr_o  <= addr;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_kind_o  <= ~kind;
    req_addr_o  <= ~addr;
  endtask
endmodule

// File: verif/tb.sv
// Self-checking bench for the diagnostic status block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned LOSS = 200;
  localparam logic [19:0] BASE = 20'h5_0000;
  logic        clk_i = 1'b0, reset_i = 1'b1, bus_sel_i = 1'b0;
  logic [6:0]  node_addr_i = 7'h05;
  logic [4:0]  mode_code_i = 5'h00;
  logic        req_valid_i;
  logic [1:0]  req_kind_i;
  logic [6:0]  req_addr_i;
  logic        amp_low_i = 1'b0, amp_high_i = 1'b0, lock_poor_i = 1'b0;
  logic        acquiring_i = 1'b0, mem_sig_fail_i = 1'b0;
  logic [19:0] snd_spd_a_i = BASE, snd_spd_b_i = BASE, snd_spd_c_i = BASE;
  logic [15:0] supply_mv_i = 16'h2ee0;
  logic [9:0]  encl_rh_i = 10'h000;
  logic [31:0] wind_x_i = 32'h0, wind_y_i = 32'h0, wind_z_i = 32'h0;
  logic [31:0] sonic_temp_i = 32'h0, encl_temp_f_i = 32'h0;
  logic [31:0] encl_rh_f_i = 32'h0, pitch_i = 32'h0, roll_i = 32'h0;
  logic        busy_o, meas_start_o, self_trig_o, resp_valid_o;
  logic        resp_last_o;
  logic [31:0] resp_data_o, diag_word_o, w [5];
  logic [6:0]  na [6] = '{7'h0e, 7'h0f, 7'h05, 7'h78, 7'h79, 7'h00};
  logic [4:0]  md [4] = '{5'h00, 5'h05, 5'h0a, 5'h19};
  logic        trig_err = 1'b0;
  int          bad_count = 0, checked = 0, cyc = 0;
  `define CHK(g, e, m) chk(32'(g), 32'(e), m)
  always #4 clk_i = ~clk_i;
  adn_diag_status #(.TRIG_LOSS_CYC(LOSS)) i_adn_diag_status (.*);
  adn_host_model u_host (.clk_i(clk_i), .req_valid_o(req_valid_i),
    .req_kind_o(req_kind_i), .req_addr_o(req_addr_i));
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic big(input logic [19:0] a, input logic [19:0] b);
    return (a > b ? a - b : b - a) > adn_pkg::DELTA_C_MAX_MMS;
  endfunction
  function automatic logic [31:0] exp_diag();
    return {23'h0, mem_sig_fail_i, encl_rh_i > adn_pkg::RH_WARN_DPCT,
      trig_err, supply_mv_i < adn_pkg::LOW_VOLT_MV, acquiring_i,
      big(snd_spd_a_i, snd_spd_b_i) || big(snd_spd_b_i, snd_spd_c_i) ||
      big(snd_spd_a_i, snd_spd_c_i), lock_poor_i, amp_high_i, amp_low_i};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic sense(input logic [4:0] f, input logic [19:0] s,
                       input logic [15:0] v, input logic [9:0] h);
    logic [31:0] e;
    @(posedge clk_i);
    {mem_sig_fail_i, acquiring_i, lock_poor_i, amp_high_i, amp_low_i} <= f;
    snd_spd_b_i <= BASE + s;
    snd_spd_c_i <= BASE + 20'($urandom % (32'(s) + 32'h1));
    supply_mv_i <= v;
    encl_rh_i <= h;
    tick(1);
    e = exp_diag();
    `CHK(diag_word_o[4:0], e[4:0], "flags");
    `CHK(diag_word_o[7:5], e[7:5], "env");
    `CHK(diag_word_o[31:8], e[31:8], "high");
  endtask
  task automatic expect_words(input int n);
    int i;
    i = 0;
    while (resp_valid_o !== 1'b1 && i < 20) begin
      tick(1);
      i++;
    end
    for (int k = 0; k < n; k++) begin
      `CHK(resp_data_o, w[k], "word");
      `CHK(resp_last_o, k == n - 1, "last");
      tick(1);
    end
    `CHK(resp_valid_o, 1'b0, "extra");
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    void'($urandom(32'he9a3d5f3));
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    tick(LOSS - 20);
    `CHK(diag_word_o[6], 1'b0, "early loss");
    tick(30);
    `CHK(diag_word_o[6], 1'b1, "loss");
    for (int k = 0; k < 4; k++) begin
      u_host.send(2'h2, 7'h7f);
      tick(0);
      `CHK(meas_start_o, 1'b1, "start");
      tick(18);
    end
    `CHK(diag_word_o[6], 1'b0, "steady");
    tick(9);
    u_host.send(2'h2, 7'h7f);
    tick(4);
    `CHK(diag_word_o[6], 1'b1, "jitter");
    trig_err = 1'b1;
    tick(LOSS);
    for (int k = 0; k < 5; k++)
      sense(5'h01 << k, adn_pkg::DELTA_C_MAX_MMS + 20'(k % 2),
        adn_pkg::LOW_VOLT_MV - 16'(k % 2), adn_pkg::RH_WARN_DPCT + 10'(k % 2));
    for (int k = 0; k < 30; k++)
      sense(5'($urandom), adn_pkg::DELTA_C_MAX_MMS - 20'h40 +
        20'($urandom % 32'h80), adn_pkg::LOW_VOLT_MV - 16'h40 +
        16'($urandom % 32'h80), adn_pkg::RH_WARN_DPCT - 10'h40 +
        10'($urandom % 32'h80));
    for (int r = 0; r < 3; r++) begin
      sense(r == 1 ? 5'h08 : 5'h00, 20'h10, 16'h2ee0, 10'h100);
      @(posedge clk_i);
      {wind_x_i, wind_y_i, wind_z_i} <= {$urandom, $urandom, $urandom};
      {sonic_temp_i, encl_temp_f_i} <= {$urandom, $urandom};
      {encl_rh_f_i, pitch_i, roll_i} <= {$urandom, $urandom, $urandom};
      tick(1);
      w = '{wind_x_i, wind_y_i, wind_z_i, sonic_temp_i, exp_diag()};
      for (int j = 0; j < 4 && r == 1; j++) w[j] = adn_pkg::FLOAT_NAN;
      u_host.send(2'h0, 7'h05);
      if (r == 2) u_host.send(2'h1, 7'h05);
      expect_words(5);
    end
    w = '{encl_temp_f_i, encl_rh_f_i, pitch_i, roll_i, 32'h0};
    u_host.send(2'h1, 7'h05);
    expect_words(4);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      bus_sel_i <= k == 3 || k == 4;
      node_addr_i <= na[k];
      u_host.send(2'h1, k == 2 ? 7'h06 : na[k]);
      tick(2);
      `CHK(busy_o, k == 0 || k == 3, "address");
      tick(12);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      bus_sel_i <= k[2];
      node_addr_i <= 7'h05;
      mode_code_i <= md[k % 4];
      tick(2);
      `CHK(self_trig_o, k[2] && k % 4 != 0, "mode");
    end
    u_host.send(2'h2, 7'h7f);
    tick(0);
    `CHK(meas_start_o, 1'b0, "network group");
    tick(2);
    u_host.send(2'h0, 7'h05);
    tick(0);
    `CHK(meas_start_o, 1'b1, "network measure");
    tick(14);
    @(posedge clk_i);
    reset_i <= 1'b1;
    tick(1);
    `CHK(diag_word_o, 32'h0, "reset status");
    `CHK(busy_o, 1'b0, "reset busy");
    @(posedge clk_i);
    reset_i <= 1'b0;
    tick(3);
    conclude();
  end
endmodule
